// ---- fbh_ctrl.sv ----
/*
 * Host controller that drives an asynchronous NOR flash through its
 * chip select, output enable, write enable, reset and acceleration pins.
 * Assumes requests arrive on ref_clk_i and dq_i is asynchronous.
 */
`timescale 1ns/1ps

// Behaviour
// - Read with select and output enable low
// - Writes: select and write low, output high
// - Bypass programs take two writes, not four
// - Buffered programming holds sixteen words
// - High voltage only during accelerated programming
// - Host restarts operation cut by reset
module fbh_ctrl #(
    parameter logic [fbh_pkg::ADDR_W-1:0] UNLK1_ADDR = 22'h000000,
    parameter logic [fbh_pkg::DATA_W-1:0] UNLK1_DATA = 16'h0000,
    parameter logic [fbh_pkg::ADDR_W-1:0] UNLK2_ADDR = 22'h000000,
    parameter logic [fbh_pkg::DATA_W-1:0] UNLK2_DATA = 16'h0000,
    parameter logic [fbh_pkg::DATA_W-1:0] PROG_CMD = 16'h0000
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input fbh_pkg::fbh_req_type req_i,
    input wire logic bypass_i,
    input wire logic accel_i,
    input wire logic flash_reset_i,
    input wire logic [fbh_pkg::DATA_W-1:0] dq_i,
    output logic req_ready_o,
    output logic resp_valid_o,
    output logic resp_err_o,
    output logic [fbh_pkg::DATA_W-1:0] resp_data_o,
    output fbh_pkg::fbh_pins_type pins_o
);
    import fbh_pkg::*;

    // =========================================================
    // State
    // =========================================================
    localparam int SW = 5; // Width of step and buffer counters.
    fbh_state_type state, next_state; // Bus sequencer.
    logic [CNT_W-1:0] cnt, next_cnt; // Delay down-counter.
    logic [SW-1:0] step, next_step; // Bus write in the sequence.
    logic [SW-1:0] nsteps, next_nsteps; // Bus writes in the sequence.
    logic [SW-1:0] buf_cnt, next_buf_cnt; // Words held for flushing.
    fbh_req_type cur, next_cur; // Request being served.
    logic fast, next_fast; // Two-write program form chosen.
    logic replay, next_replay; // Request cut by a flash reset.
    logic page_open, next_page_open; // Select held since a read.
    logic [ADDR_W-1:PAGE_LSB] page_tag, next_page_tag; // Open page.
    fbh_pins_type pins, next_pins; // Registered pin levels.
    logic ready, next_ready; // May take a request.
    logic rvalid, next_rvalid; // Answer pulse.
    logic rerr, next_rerr; // Answer carries a refusal.
    logic [DATA_W-1:0] rdata, next_rdata; // Answer data.
    logic [DATA_W-1:0] dq_s1, dq_s2; // Data input synchroniser.
    logic [DATA_W-1:0] buf_rdata; // Word read from the buffer.
    fbh_req_type disp; // Request dispatched this cycle.
    logic accept; // A request starts this cycle.
    logic push_en; // Buffer write strobe.

    // Address of bus write k of the current sequence.
    function automatic logic [ADDR_W-1:0] bus_addr(input fbh_req_type r,
            input logic f, input logic [SW-1:0] k);
        logic [SW-1:0] i;
        i = f ? SW'(k + 5'h02) : k;
        if (r.op == OP_BUF_FLUSH) begin
            return r.addr + ADDR_W'(k);
        end else if (r.op != OP_PROG || i == 5'h03) begin
            return r.addr;
        end else if (i == 5'h01) begin
            return UNLK2_ADDR;
        end
        return UNLK1_ADDR;
    endfunction

    // =========================================================
    // Buffer for buffered programming
    // =========================================================
    fbh_wbuf #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH), .AW(SW - 1)) u_wbuf (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(push_en),
        .wr_addr_i(buf_cnt[SW-2:0]),
        .wr_data_i(disp.data),
        .rd_addr_i(next_step[SW-2:0]),
        .rd_data_o(buf_rdata)
    );

    // Two flip-flops before any logic looks at the flash data pins.
    always_ff @(posedge ref_clk_i) begin
        dq_s1 <= dq_i;
        dq_s2 <= dq_s1;
    end

    // =========================================================
    // Sequencer next-state logic
    // =========================================================
    // A replayed request wins over a new one so a reset never loses work.
    always_comb begin
        disp = replay ? cur : req_i;
        accept = (state == ST_IDLE) && !flash_reset_i
            && (replay || (req_valid_i && ready));
        push_en = accept && disp.op == OP_BUF_PUSH
            && buf_cnt < SW'(BUF_DEPTH);
        next_state = state;
        next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_step = step;
        next_nsteps = nsteps;
        next_buf_cnt = push_en ? buf_cnt + 1'b1 : buf_cnt;
        next_cur = cur;
        next_fast = fast;
        next_replay = replay;
        next_page_open = page_open;
        next_page_tag = page_tag;
        next_pins = pins;
        next_rvalid = 1'b0;
        next_rerr = 1'b0;
        next_rdata = rdata;
        if (flash_reset_i && state != ST_RST && state != ST_REC) begin
            // Pulse reset, park every control pin and remember unfinished work.
            next_replay = (state != ST_IDLE) || replay;
            next_state = ST_RST;
            next_cnt = CNT_W'(RP_CYC - 1);
            next_pins.rst_n = 1'b0;
            next_pins.ce_n = 1'b1;
            next_pins.oe_n = 1'b1;
            next_pins.we_n = 1'b1;
            next_pins.dq_oe = 1'b0;
            next_pins.high_program_voltage_en = 1'b0;
            next_page_open = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (accept) begin
                        next_replay = 1'b0;
                        next_cur = disp;
                        next_step = '0;
                        next_fast = bypass_i || accel_i;
                        if (disp.op == OP_READ) begin
                            // Same page with select held: short access.
                            if (page_open && disp.addr[ADDR_W-1:PAGE_LSB]
                                    == page_tag) begin
                                next_cnt = CNT_W'(PACC_CYC + SYNC_CYC - 1);
                            end else begin
                                next_cnt = CNT_W'(ACC_CYC + SYNC_CYC - 1);
                            end
                            next_pins.addr = disp.addr;
                            next_pins.ce_n = 1'b0;
                            next_pins.oe_n = 1'b0;
                            next_pins.we_n = 1'b1;
                            next_state = ST_READ;
                        end else if (disp.op == OP_BUF_PUSH) begin
                            next_rvalid = 1'b1;
                            next_rerr = !push_en;
                        end else if (disp.op == OP_BUF_FLUSH
                                && buf_cnt == '0) begin
                            next_rvalid = 1'b1;
                        end else begin
                            // Any write closes the page first.
                            next_page_open = 1'b0;
                            if (disp.op == OP_PROG) begin
                                next_nsteps = (bypass_i || accel_i)
                                    ? SW'(PROG_FAST_CYC)
                                    : SW'(PROG_STD_CYC);
                                next_pins.high_program_voltage_en =
                                    accel_i;
                            end else if (disp.op == OP_BUF_FLUSH) begin
                                next_nsteps = buf_cnt;
                            end else begin
                                next_nsteps = 5'h01;
                            end
                            next_pins.addr = bus_addr(disp,
                                bypass_i || accel_i, '0);
                            next_pins.ce_n = 1'b0;
                            next_pins.oe_n = 1'b1;
                            next_state = ST_SETUP;
                        end
                    end
                end
                ST_READ: begin
                    if (cnt == '0) begin
                        // Keep select low so the next in-page read is fast.
                        next_rdata = dq_s2;
                        next_rvalid = 1'b1;
                        next_page_open = 1'b1;
                        next_page_tag = pins.addr[ADDR_W-1:PAGE_LSB];
                        next_state = ST_IDLE;
                    end
                end
                ST_SETUP: begin
                    // Drive data only while output enable is high.
                    if (cur.op == OP_BUF_FLUSH) begin
                        next_pins.dq_out = buf_rdata;
                    end else if (cur.op != OP_PROG
                            || step == nsteps - 1'b1) begin
                        next_pins.dq_out = cur.data;
                    end else if (step == nsteps - 5'h02) begin
                        next_pins.dq_out = PROG_CMD;
                    end else if (step == 5'h01) begin
                        next_pins.dq_out = UNLK2_DATA;
                    end else begin
                        next_pins.dq_out = UNLK1_DATA;
                    end
                    next_pins.dq_oe = 1'b1;
                    next_pins.we_n = 1'b0;
                    next_cnt = CNT_W'(WP_CYC - 1);
                    next_state = ST_WLOW;
                end
                ST_WLOW: begin
                    if (cnt == '0) begin
                        next_pins.we_n = 1'b1;
                        next_state = ST_WHIGH;
                    end
                end
                ST_WHIGH: begin
                    // Data is held across the rising write edge.
                    next_pins.dq_oe = 1'b0;
                    if (step + 1'b1 < nsteps) begin
                        next_step = step + 1'b1;
                        next_pins.addr = bus_addr(cur, fast, step + 1'b1);
                        next_state = ST_SETUP;
                    end else begin
                        next_pins.ce_n = 1'b1;
                        next_pins.high_program_voltage_en = 1'b0;
                        next_rvalid = 1'b1;
                        if (cur.op == OP_BUF_FLUSH) begin
                            next_buf_cnt = '0;
                        end
                        next_state = ST_IDLE;
                    end
                end
                ST_RST: begin
                    if (cnt == '0) begin
                        next_pins.rst_n = 1'b1;
                        next_cnt = CNT_W'(RH_CYC - 1);
                        next_state = ST_REC;
                    end
                end
                ST_REC: begin
                    if (cnt == '0) begin
                        next_state = ST_IDLE;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
        next_ready = (next_state == ST_IDLE) && !next_replay && !accept;
    end

    // Registers only; reset parks the bus deselected and released.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state <= ST_IDLE;
            cnt <= '0;
            step <= '0;
            nsteps <= '0;
            buf_cnt <= '0;
            cur <= '0;
            fast <= 1'b0;
            replay <= 1'b0;
            page_open <= 1'b0;
            page_tag <= '0;
            pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
                default: '0};
            ready <= 1'b0;
            rvalid <= 1'b0;
            rerr <= 1'b0;
            rdata <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            step <= next_step;
            nsteps <= next_nsteps;
            buf_cnt <= next_buf_cnt;
            cur <= next_cur;
            fast <= next_fast;
            replay <= next_replay;
            page_open <= next_page_open;
            page_tag <= next_page_tag;
            pins <= next_pins;
            ready <= next_ready;
            rvalid <= next_rvalid;
            rerr <= next_rerr;
            rdata <= next_rdata;
        end
    end

    assign req_ready_o = ready;
    assign resp_valid_o = rvalid;
    assign resp_err_o = rerr;
    assign resp_data_o = rdata;
    assign pins_o = pins;

    // =========================================================
    // Checks
    // =========================================================
    logic [CNT_W-1:0] rst_low_cnt; // Cycles the flash reset has been low.
    logic [SW-1:0] wr_seen; // Bus writes since the request started.
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i || pins.rst_n) begin
            rst_low_cnt <= '0;
        end else begin
            rst_low_cnt <= rst_low_cnt + 1'b1;
        end
        if (!nrst_i || state == ST_IDLE) begin
            wr_seen <= '0;
        end else if (state == ST_SETUP) begin
            wr_seen <= wr_seen + 1'b1;
        end
    end

    a_read_levels: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state == ST_READ |-> !pins.ce_n && !pins.oe_n && pins.we_n)
        else $error("read without select and output enable low");
    a_write_levels: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        !pins.we_n |-> !pins.ce_n && pins.oe_n)
        else $error("write strobe with bad select or output enable");
    a_write_width: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i || !pins.rst_n)
        $fell(pins.we_n) |-> (!pins.we_n) [*7] ##1 pins.we_n)
        else $error("write pulse not seven cycles");
    a_dq_float: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        pins.dq_oe |-> pins.oe_n)
        else $error("data driven while output enable low");
    a_hv_only_prog: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        pins.high_program_voltage_en |-> cur.op == OP_PROG
            && state inside {ST_SETUP, ST_WLOW, ST_WHIGH})
        else $error("high voltage outside programming");
    a_reset_width: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        $rose(pins.rst_n) |-> rst_low_cnt >= CNT_W'(RP_CYC))
        else $error("flash reset pulse too short");
    a_buf_cap: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        buf_cnt <= SW'(BUF_DEPTH))
        else $error("write buffer over sixteen words");
    a_prog_count: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        rvalid && cur.op == OP_PROG
            |-> wr_seen == (fast ? 5'h02 : 5'h04))
        else $error("program used wrong number of writes");
    a_page_closed: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        pins.ce_n |-> !page_open)
        else $error("page kept open across deselect");
    a_replay_after: assert property (@(posedge ref_clk_i)
        disable iff (!nrst_i)
        state == ST_REC && cnt == '0 && replay
            |-> ##1 state == ST_IDLE ##1 state != ST_IDLE)
        else $error("cut request not restarted");

endmodule

// ---- fbh_pkg.sv ----
/*
 * Shared constants and types for the host-side controller of an
 * asynchronous NOR flash bus with page reads and buffered programming.
 * Assumes a single 200 MHz clock and a flash that needs no clock.
 */
package fbh_pkg;

    // =========================================================
    // Bus widths and page layout
    // =========================================================
    localparam int ADDR_W = 22; // Word address width of the array.
    localparam int DATA_W = 16; // Data bus width in word mode.
    localparam int PAGE_LSB = 2; // Bits below this pick the word in a page.
    localparam int BUF_DEPTH = 16; // Most words in one buffered program.
    localparam int PROG_STD_CYC = 4; // Bus writes per standard program.
    localparam int PROG_FAST_CYC = 2; // Bus writes per bypass program.
    localparam int SYNC_CYC = 2; // Flip-flops on the data input path.
    localparam int CNT_W = 16; // Width of the delay counter.

    // =========================================================
    // Timing, in nanoseconds and in clock cycles
    // =========================================================
    localparam int CLK_PERIOD_PS = 5000; // 200 MHz reference clock.
    localparam int ADDRESS_ACCESS_TIME_NS = 100; // Address to data access time.
    localparam int PAGE_ACCESS_TIME_NS = 25; // Access time inside an open page.
    localparam int T_WP_NS = 35; // Write enable low width.
    localparam int T_RP_NS = 500; // Least reset pulse width.
    localparam int T_RH_NS = 50; // Recovery after reset release.

    // Rounds a least time up to whole clock cycles, never below one.
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACC_CYC = ns_to_cyc(ADDRESS_ACCESS_TIME_NS); // address_access_time.
    localparam int PACC_CYC = ns_to_cyc(PAGE_ACCESS_TIME_NS); // page_access_time.
    localparam int WP_CYC = ns_to_cyc(T_WP_NS); // Write pulse cycles.
    localparam int RP_CYC = ns_to_cyc(T_RP_NS); // reset_pulse_min_width.
    localparam int RH_CYC = ns_to_cyc(T_RH_NS); // Recovery cycles.

    // =========================================================
    // Operations, states and carriers
    // =========================================================
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_PROG = 3'h2,
        OP_BUF_PUSH = 3'h3,
        OP_BUF_FLUSH = 3'h4
    } fbh_op_type;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_READ = 7'h02,
        ST_SETUP = 7'h04,
        ST_WLOW = 7'h08,
        ST_WHIGH = 7'h10,
        ST_RST = 7'h20,
        ST_REC = 7'h40
    } fbh_state_type;

    // One request from the user side.
    typedef struct packed {
        fbh_op_type op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbh_req_type;

    // Every pin that the controller drives toward the flash.
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic high_program_voltage_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } fbh_pins_type;

endpackage

// ---- fbh_wbuf.sv ----
/*
 * Small word store that holds data for one buffered program.
 * Assumes one clock; the read word comes out of a register one edge
 * after its address is presented.
 */
`timescale 1ns/1ps
module fbh_wbuf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic ref_clk_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);

    // =========================================================
    // Storage
    // =========================================================
    logic [WIDTH-1:0] mem [DEPTH]; // Data words; no reset is needed.

    // Writes land on the edge; the read word is registered.
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule

// ---- fbh_flash_model.sv ----
/* Behavioural flash that answers the host controller's pins.
   Assumes the pin struct of fbh_pkg and the bench clock for timing. */
`timescale 1ns/1ps
module fbh_flash_model
    import fbh_pkg::*;
(
    input wire logic ref_clk_i,
    input fbh_pkg::fbh_pins_type pins_i,
    output logic [fbh_pkg::DATA_W-1:0] dq_o
);
    // ====================
    // State seen by the bench
    // ====================
    logic [38:0] wlog[$]; // Writes taken: {hv, addr, data}.
    int stable_cyc = 0; // Cycles the address has held still.
    int need_cyc = ACC_CYC; // Access time owed by this read.
    int rst_cnt = 0; // Running count of reset low cycles.
    int rst_w = 0; // Width of the last reset pulse.
    int hv_bad = 0; // High voltage seen during a read.
    logic was_sel = 1'b0; // Select was low at the last edge.
    logic prev_we_n = 1'b1; // Write enable at the last edge.
    logic [ADDR_W-1:0] prev_addr = '0; // Address at the last edge.
    logic [DATA_W-1:0] last_q = '0; // Last value on the pins.
    logic drive; // Pins carry valid array data.

    // Data shows only once the access time has run, so early sampling
    // sees a changing pattern instead of a lucky match.
    assign drive = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n
        && pins_i.rst_n && pins_i.addr == prev_addr
        && stable_cyc + 2 >= need_cyc;
    // No identification sequence is ever written, so reads stay on the array.
    assign dq_o = drive ? {~pins_i.addr[7:0], pins_i.addr[7:0]} : ~last_q;

    // ====================
    // Timing, write capture and reset width
    // ====================
    always @(posedge ref_clk_i) begin
        if (pins_i.ce_n || !pins_i.rst_n) begin
            stable_cyc <= 0;
            need_cyc <= ACC_CYC;
        end else if (pins_i.addr != prev_addr) begin
            stable_cyc <= 0;
            need_cyc <= (was_sel && pins_i.addr[ADDR_W-1:PAGE_LSB]
                == prev_addr[ADDR_W-1:PAGE_LSB]) ? PACC_CYC : ACC_CYC;
        end else begin
            stable_cyc <= stable_cyc + 1;
        end
        // Every write is taken: no sector is protected,
        // and a logged cycle stays logged after deselect.
        if (pins_i.we_n && !prev_we_n && !pins_i.ce_n && pins_i.oe_n
            && pins_i.rst_n && pins_i.dq_oe) begin
            wlog.push_back({pins_i.high_program_voltage_en, pins_i.addr,
                pins_i.dq_out});
        end
        if (pins_i.high_program_voltage_en && !pins_i.oe_n) begin
            hv_bad <= hv_bad + 1;
        end
        rst_cnt <= pins_i.rst_n ? 0 : rst_cnt + 1;
        if (pins_i.rst_n && rst_cnt > 0) begin
            rst_w <= rst_cnt;
        end
        was_sel <= !pins_i.ce_n;
        prev_we_n <= pins_i.we_n;
        prev_addr <= pins_i.addr;
        last_q <= dq_o;
    end
endmodule

// ---- flash_async_bus_operations_bench.sv ----
/* Self-checking bench for the flash host controller.
   Assumes the behavioural flash model on the far side of the pins. */
`timescale 1ns/1ps
module flash_async_bus_operations_bench;
    import fbh_pkg::*;
    // ====================
    // Signals and counters
    // ====================
    logic ref_clk_i = 1'b0; // 200 MHz clock.
    logic nrst_i = 1'b0; // Held low for five cycles.
    logic req_valid_i = 1'b0; // Request strobe.
    fbh_req_type req_i = '0; // Request fields.
    logic bypass_i = 1'b0; // Flash already in bypass mode.
    logic accel_i = 1'b0; // Program under high voltage.
    logic flash_reset_i = 1'b0; // Asks for a flash reset pulse.
    logic [DATA_W-1:0] dq, resp_data_o, rd; // Flash data, answers.
    logic req_ready_o, resp_valid_o, resp_err_o, err;
    fbh_pins_type pins_o; // Pins toward the flash.
    int num_errors = 0, checks_done = 0, cycles = 0, lat = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    fbh_ctrl #(.UNLK1_ADDR(22'h000555), .UNLK1_DATA(16'h00AA),
        .UNLK2_ADDR(22'h0002AA), .UNLK2_DATA(16'h0055),
        .PROG_CMD(16'h00A0)) dut_u (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .bypass_i(bypass_i), .accel_i(accel_i),
        .flash_reset_i(flash_reset_i), .dq_i(dq),
        .req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o),
        .resp_err_o(resp_err_o), .resp_data_o(resp_data_o),
        .pins_o(pins_o));
    fbh_flash_model flash_u (.ref_clk_i(ref_clk_i), .pins_i(pins_o),
        .dq_o(dq));

    // ====================
    // Shared tasks
    // ====================
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One request, held until taken; lat counts edges from the taking
    // edge to the answer, both included. An edge passes first so valid
    // is never dropped and raised again in one time step.
    task automatic op(input fbh_op_type o, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        @(posedge ref_clk_i) #1;
        req_i = '{op: o, addr: a, data: d};
        req_valid_i = 1'b1;
        while (!req_ready_o) @(posedge ref_clk_i) #1;
        @(posedge ref_clk_i) #1;
        req_valid_i = 1'b0;
        lat = 1;
        while (!resp_valid_o && lat < 400) begin
            @(posedge ref_clk_i) #1;
            lat++;
        end
        rd = resp_data_o;
        err = resp_err_o;
    endtask

    // ====================
    // Scenarios
    // ====================
    task automatic s_read();
        op(OP_READ, 22'h000105, '0);
        chk(rd, 16'hFA05);
        chk(lat, 23);
        op(OP_READ, 22'h000106, '0);
        chk({rd, lat[7:0]}, {16'hF906, 8'h08});
        op(OP_READ, 22'h000109, '0);
        chk({rd, lat[7:0]}, {16'hF609, 8'h17});
    endtask

    task automatic s_write();
        op(OP_WRITE, 22'h000123, 16'hBEEF);
        chk(lat, 10);
        chk(flash_u.wlog[$], {1'b0, 22'h000123, 16'hBEEF});
        op(OP_READ, 22'h000106, '0);
        chk({rd, lat[7:0]}, {16'hF906, 8'h17});
    endtask

    // Standard, bypass and high-voltage programs in turn.
    task automatic s_prog();
        int n;
        logic [21:0] pa;
        for (int f = 0; f < 3; f++) begin
            bypass_i = (f == 1);
            accel_i = (f == 2);
            pa = 22'h000200 + 22'(f);
            n = flash_u.wlog.size();
            op(OP_PROG, pa, 16'h1230);
            chk(flash_u.wlog.size() - n, (f == 0) ? 4 : 2);
            chk(lat, (f == 0) ? 37 : 19);
            chk(flash_u.wlog[$], {f == 2, pa, 16'h1230});
            chk(flash_u.wlog[n][37:0], (f == 0) ? {22'h000555, 16'h00AA}
                : {22'h000555, 16'h00A0});
        end
        bypass_i = 1'b0;
        accel_i = 1'b0;
        chk({flash_u.hv_bad, pins_o.high_program_voltage_en}, 0);
    endtask

    // Fill past the limit, then flush to consecutive addresses.
    task automatic s_buf();
        int n;
        for (int k = 0; k <= BUF_DEPTH; k++) begin
            op(OP_BUF_PUSH, '0, 16'hA500 + 16'(k));
            chk(err, k == BUF_DEPTH);
        end
        n = flash_u.wlog.size();
        op(OP_BUF_FLUSH, 22'h000300, '0);
        chk(flash_u.wlog.size() - n, BUF_DEPTH);
        for (int k = 0; k < BUF_DEPTH; k++) begin
            chk(flash_u.wlog[n + k], {1'b0, 22'h000300 + 22'(k),
                16'hA500 + 16'(k)});
        end
        op(OP_BUF_FLUSH, 22'h000300, '0);
        chk(lat, 1);
    endtask

    // Flash reset cuts a write in its low phase; the write is replayed.
    task automatic s_reset();
        fork
            op(OP_WRITE, 22'h000321, 16'h5AA5);
            begin
                repeat (4) @(posedge ref_clk_i);
                #1 flash_reset_i = 1'b1;
                @(posedge ref_clk_i) #1;
                flash_reset_i = 1'b0;
            end
        join
        chk(flash_u.rst_w, RP_CYC);
        chk(flash_u.wlog[$], {1'b0, 22'h000321, 16'h5AA5});
        op(OP_READ, 22'h000105, '0);
        chk({rd, lat[7:0]}, {16'hFA05, 8'h17});
    endtask

    initial begin
        repeat (5) @(posedge ref_clk_i);
        #1 nrst_i = 1'b1;
        @(posedge ref_clk_i) #1;
        s_read();
        s_write();
        s_prog();
        s_buf();
        s_reset();
        tally_and_finish();
    end

    // The whole run needs well under 2000 cycles.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
endmodule
